// ---- rtl/spm_pkg.sv ----
package spm_pkg;

  // Register port widths
  localparam int SPM_AW = 16;
  localparam int SPM_DW = 16;

  // Register offsets on the register port
  localparam logic [SPM_AW-1:0] SPM_OFF_GLOBAL_SOFT_RESET = 16'h0216;
  localparam logic [SPM_AW-1:0] SPM_OFF_PM_CAPS           = 16'h0218;
  localparam logic [SPM_AW-1:0] SPM_OFF_IRQ_STATUS        = 16'h0240;
  localparam logic [SPM_AW-1:0] SPM_OFF_IRQ_MASK          = 16'h0242;
  localparam logic [SPM_AW-1:0] SPM_OFF_PM_VIEW           = 16'h0244;

  // Soft reset control field
  localparam int   SPM_GSR_BIT   = 0;
  localparam logic SPM_GSR_RESET = 1'b0;

  // Capability field positions
  localparam int SPM_CAP_D3COLD_EVT = 15;
  localparam int SPM_CAP_D3HOT_EVT  = 14;
  localparam int SPM_CAP_D2_EVT     = 13;
  localparam int SPM_CAP_D1_EVT     = 12;
  localparam int SPM_CAP_D0_EVT     = 11;
  localparam int SPM_CAP_EEPROM_D2_SUPPORT_FLAG     = 10;
  localparam int SPM_CAP_EEPROM_D1_SUPPORT_FLAG     = 9;
  localparam int SPM_CAP_AUX_LSB    = 6;
  localparam int SPM_CAP_DSI        = 5;
  localparam int SPM_CAP_EVT_CLK    = 3;
  localparam int SPM_CAP_VER_LSB    = 0;

  // Capability reset value: only the hot D3 event bit is set
  localparam logic [SPM_DW-1:0] SPM_CAPS_RESET = 16'h4000;

  // Configuration word that carries the capability fields
  localparam logic [7:0] SPM_EE_CFG_ADDR = 8'h06;

  // Interrupt status bit positions
  localparam int SPM_IRQ_CAPS_LOADED = 0;
  localparam int SPM_IRQ_WAKE        = 1;
  localparam int SPM_IRQ_SRST_DONE   = 2;
  localparam int SPM_IRQ_N           = 3;

  // Read view of block state
  localparam int SPM_VIEW_PSTATE_LSB = 0;
  localparam int SPM_VIEW_WAKE       = 2;
  localparam int SPM_VIEW_EE_EN      = 3;
  localparam int SPM_VIEW_SRST       = 4;

  // Power states as seen by the block
  typedef enum logic [1:0] {
    SPM_D0     = 2'b00,
    SPM_D1     = 2'b01,
    SPM_D2     = 2'b10,
    SPM_D3_HOT = 2'b11
  } spm_pstate_t;

  // Capability register layout
  typedef struct packed {
    logic       d3cold_evt;
    logic       d3hot_evt;
    logic       d2_evt;
    logic       d1_evt;
    logic       d0_evt;
    logic       eeprom_d2_support_flag;
    logic       eeprom_d1_support_flag;
    logic [2:0] aux_cur;
    logic       dsi;
    logic       rsvd4;
    logic       evt_clk;
    logic [2:0] version;
  } spm_caps_t;

  // Configuration word arriving from the serial loader
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [15:0] data;
  } spm_ee_word_t;

endpackage

// ---- rtl/spm_irq_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module spm_irq_bank
  import spm_pkg::*;
#(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Block-level clear
  input  wire logic         clr,
  // Events, one-cycle pulses
  input  wire logic [N-1:0] set_ev,
  // Software access
  input  wire logic         wr_status,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  // State
  output logic      [N-1:0] status_ff,
  output logic      [N-1:0] mask_ff,
  output logic              irq_ff
);

  logic [N-1:0] nxt_status;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~wdata;
    end
    nxt_status = nxt_status | set_ev;
  end

  // Sticky status
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Mask register, one enables the bit
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      mask_ff <= '0;
    end else if (wr_mask) begin
      mask_ff <= wdata;
    end
  end

  // Level output, registered so it has no glitches
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

endmodule // spm_irq_bank

`default_nettype wire

// ---- rtl/spm_top.sv ----
// Summary of operation
// - bit 0 of soft reset register is read/write
// - soft reset clears all but configuration space
// - capabilities read-only, loaded from word 0x6
// - capabilities mirrored to capability word upper half
// - cold D3 event bit always reads 0
// - hot D3 bit reads 1, event allowed
// - D2 event needs loaded flag and enable
// - D1 event needs loaded flag and enable
// - D0 bit reads 0, never event
// - D2/D1 support loaded, zero without EEPROM
// - auxiliary current field always reads 000
// - special initialization flag loaded from EEPROM
// - event clock flag loaded from EEPROM
// - interface version loaded from three bits
`timescale 1ns/1ps
`default_nettype none

module spm_top
  import spm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [SPM_AW-1:0] reg_addr,
  input  wire logic [SPM_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [SPM_DW-1:0] reg_rdata,
  // Configuration EEPROM side
  input  wire logic              eeprom_enable_pin,
  input  wire spm_ee_word_t      ee_word,
  // Power management side
  input  wire spm_pstate_t       power_state,
  input  wire logic              wake_event_enable,
  input  wire logic              wake_request,
  output logic                   wake_event_output,
  // Configuration space mirror
  output logic      [SPM_DW-1:0] pci_capability_id_word_hi,
  // Soft reset to the rest of the device
  output logic                   soft_reset_active,
  // Interrupt
  output logic                   irq
);

  // Internal state
  logic              soft_reset_ff;
  logic              nxt_soft_reset;
  logic              srst_q_ff;
  spm_caps_t         caps_ff;
  spm_caps_t         nxt_caps;
  logic              loaded_ff;
  logic [SPM_DW-1:0] mirror_ff;
  logic [SPM_DW-1:0] rdata_ff;
  logic [SPM_DW-1:0] nxt_rdata;
  logic              wake_ff;
  logic              nxt_wake;
  logic              wake_allowed;
  logic [SPM_IRQ_N-1:0] irq_status;
  logic [SPM_IRQ_N-1:0] irq_mask;
  logic [SPM_IRQ_N-1:0] irq_set;
  logic              irq_ff;

  // Address decode
  logic hit_gsr;
  logic hit_caps;
  logic hit_ists;
  logic hit_imsk;
  logic hit_view;

  assign hit_gsr  = (reg_addr == SPM_OFF_GLOBAL_SOFT_RESET);
  assign hit_caps = (reg_addr == SPM_OFF_PM_CAPS);
  assign hit_ists = (reg_addr == SPM_OFF_IRQ_STATUS);
  assign hit_imsk = (reg_addr == SPM_OFF_IRQ_MASK);
  assign hit_view = (reg_addr == SPM_OFF_PM_VIEW);

  // Soft reset bit: stays set until software writes zero
  always_comb begin
    nxt_soft_reset = soft_reset_ff;
    if (reg_wr && hit_gsr) begin
      nxt_soft_reset = reg_wdata[SPM_GSR_BIT];
    end
  end

  // Of the two resets only hardware reset clears the soft reset control itself
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_ff <= SPM_GSR_RESET;
    end else begin
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  // Delayed copy, used to spot the release of soft reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srst_q_ff <= 1'b0;
    end else begin
      srst_q_ff <= soft_reset_ff;
    end
  end

  // Capability load: fixed bits are forced, the rest come from word 0x6
  always_comb begin
    nxt_caps = caps_ff;
    if (!eeprom_enable_pin) begin
      // Without an EEPROM every loaded field falls back to its default
      nxt_caps = spm_caps_t'(SPM_CAPS_RESET);
    end else if (ee_word.valid && (ee_word.addr == SPM_EE_CFG_ADDR)) begin
      nxt_caps.d2_evt  = ee_word.data[SPM_CAP_D2_EVT];
      nxt_caps.d1_evt  = ee_word.data[SPM_CAP_D1_EVT];
      nxt_caps.eeprom_d2_support_flag  = ee_word.data[SPM_CAP_EEPROM_D2_SUPPORT_FLAG];
      nxt_caps.eeprom_d1_support_flag  = ee_word.data[SPM_CAP_EEPROM_D1_SUPPORT_FLAG];
      nxt_caps.dsi     = ee_word.data[SPM_CAP_DSI];
      nxt_caps.evt_clk = ee_word.data[SPM_CAP_EVT_CLK];
      nxt_caps.version = ee_word.data[SPM_CAP_VER_LSB +: 3];
    end
    // Hard-wired fields, whatever the EEPROM holds
    nxt_caps.d3cold_evt = 1'b0;
    nxt_caps.d3hot_evt  = 1'b1;
    nxt_caps.d0_evt     = 1'b0;
    nxt_caps.aux_cur    = 3'h0;
    nxt_caps.rsvd4      = 1'b0;
  end

  // Capabilities belong to configuration space: soft reset leaves them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      caps_ff <= spm_caps_t'(SPM_CAPS_RESET);
    end else begin
      caps_ff <= nxt_caps;
    end
  end

  // Load pulse for the interrupt status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= eeprom_enable_pin && ee_word.valid
                   && (ee_word.addr == SPM_EE_CFG_ADDR);
    end
  end

  // Mirror into the upper half of the capability word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mirror_ff <= SPM_CAPS_RESET;
    end else begin
      mirror_ff <= nxt_caps;
    end
  end

  // Which power states may raise the wake event
  always_comb begin
    wake_allowed = 1'b0;
    unique case (power_state)
      SPM_D0:     wake_allowed = caps_ff.d0_evt;
      SPM_D1:     wake_allowed = caps_ff.d1_evt;
      SPM_D2:     wake_allowed = caps_ff.d2_evt;
      SPM_D3_HOT: wake_allowed = caps_ff.d3hot_evt;
    endcase
  end

  // Enable gates every state; soft reset silences the output
  always_comb begin
    nxt_wake = wake_request && wake_event_enable && wake_allowed;
    if (nxt_soft_reset) begin
      nxt_wake = 1'b0;
    end
  end

  // Registered wake output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
    end
  end

  // Interrupt events, each a one-cycle pulse
  always_comb begin
    irq_set = '0;
    irq_set[SPM_IRQ_CAPS_LOADED] = loaded_ff;
    irq_set[SPM_IRQ_WAKE]        = nxt_wake && !wake_ff;
    irq_set[SPM_IRQ_SRST_DONE]   = srst_q_ff && !soft_reset_ff;
  end

  // Status and mask; soft reset returns both to zero
  // Clear follows the next soft reset value, like the wake blanking,
  // so an event raised on the release edge is kept, not wiped
  spm_irq_bank #(
    .N (SPM_IRQ_N)
  ) u_irq (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (nxt_soft_reset),
    .set_ev    (irq_set),
    .wr_status (reg_wr && hit_ists && !soft_reset_ff),
    .wr_mask   (reg_wr && hit_imsk && !soft_reset_ff),
    .wdata     (reg_wdata[SPM_IRQ_N-1:0]),
    .status_ff (irq_status),
    .mask_ff   (irq_mask),
    .irq_ff    (irq_ff)
  );

  // Read mux; unmapped addresses return zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      if (hit_gsr) begin
        nxt_rdata[SPM_GSR_BIT] = soft_reset_ff;
      end else if (hit_caps) begin
        nxt_rdata = caps_ff;
      end else if (hit_ists) begin
        nxt_rdata[SPM_IRQ_N-1:0] = irq_status;
      end else if (hit_imsk) begin
        nxt_rdata[SPM_IRQ_N-1:0] = irq_mask;
      end else if (hit_view) begin
        nxt_rdata[SPM_VIEW_PSTATE_LSB +: 2] = power_state;
        nxt_rdata[SPM_VIEW_WAKE]  = wake_ff;
        nxt_rdata[SPM_VIEW_EE_EN] = eeprom_enable_pin;
        nxt_rdata[SPM_VIEW_SRST]  = soft_reset_ff;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata                 = rdata_ff;
  assign wake_event_output         = wake_ff;
  assign pci_capability_id_word_hi = mirror_ff;
  assign soft_reset_active         = soft_reset_ff;
  assign irq                       = irq_ff;

endmodule // spm_top

`default_nettype wire

// ---- dv/spm_ee_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module spm_ee_model
  import spm_pkg::*;
(
  // Clock and board strap
  input  wire logic         clk,
  input  wire logic         fit,
  // Loader side
  output wire logic         eeprom_enable_pin,
  output var  spm_ee_word_t ee_word
);
  // Strap follows whether a part is fitted
  assign eeprom_enable_pin = fit;

  initial ee_word = '0;

  // One word per call; idle bus shows inverted data, not a stale copy
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    ee_word <= '{1'b1, a, d};
    @(posedge clk);
    ee_word <= '{1'b0, ~a, ~d};
  endtask
endmodule // spm_ee_model

`default_nettype wire

// ---- dv/spm_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module spm_top_assertions
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [SPM_AW-1:0] reg_addr,
  input wire logic [SPM_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [SPM_DW-1:0] reg_rdata,
  // Loader and power side
  input wire logic              eeprom_enable_pin,
  input wire spm_ee_word_t      ee_word,
  input wire spm_pstate_t       power_state,
  input wire logic              wake_event_enable,
  input wire logic              wake_request,
  input wire logic              wake_event_output,
  // Mirror, soft reset, interrupt
  input wire logic [SPM_DW-1:0] pci_capability_id_word_hi,
  input wire logic              soft_reset_active,
  input wire logic              irq
);
  logic [SPM_DW-1:0] cap;
  logic              wk;
  logic              en;

  // Short aliases keep the properties readable
  assign cap = pci_capability_id_word_hi;
  assign wk  = wake_event_output;
  assign en  = wake_event_enable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_fixed;
    cap[15:14] == 2'h1 && !cap[11] && cap[8:6] == 3'h0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("cap fixed");

  property p_d0;
    power_state == SPM_D0 |=> !wk;
  endproperty
  a_d0: assert property (p_d0) else $error("wake in D0");

  property p_d3;
    power_state == SPM_D3_HOT && en && wake_request && !soft_reset_active
      |=> wk || soft_reset_active;
  endproperty
  a_d3: assert property (p_d3) else $error("no wake D3");

  property p_d1;
    power_state == SPM_D1 && !(cap[12] && en) |=> !wk;
  endproperty
  a_d1: assert property (p_d1) else $error("wake in D1");

  property p_d2;
    power_state == SPM_D2 && !(cap[13] && en) |=> !wk;
  endproperty
  a_d2: assert property (p_d2) else $error("wake in D2");

  property p_srst;
    reg_wr && reg_addr == SPM_OFF_GLOBAL_SOFT_RESET
      |=> soft_reset_active == $past(reg_wdata[0]);
  endproperty
  a_srst: assert property (p_srst) else $error("soft bit");

  property p_hold;
    soft_reset_active && $past(soft_reset_active) |-> !wk && !irq;
  endproperty
  a_hold: assert property (p_hold) else $error("soft hold");

  property p_load;
    eeprom_enable_pin && ee_word.valid && ee_word.addr == SPM_EE_CFG_ADDR
      |=> cap == (($past(ee_word.data) & 16'h362F) | 16'h4000);
  endproperty
  a_load: assert property (p_load) else $error("load");
endmodule // spm_top_assertions

bind spm_top spm_top_assertions u_spm_top_assertions (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .eeprom_enable_pin, .ee_word, .power_state, .wake_event_enable,
  .wake_request, .wake_event_output, .pci_capability_id_word_hi,
  .soft_reset_active, .irq
);

`default_nettype wire

// ---- dv/tb_spm_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_spm_top
  import spm_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [SPM_AW-1:0] reg_addr = '0;
  logic [SPM_DW-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              fit = 1'b0;
  spm_pstate_t       power_state = SPM_D0;
  logic              wake_event_enable = 1'b0;
  logic              wake_request = 1'b0;
  logic              eeprom_enable_pin;
  spm_ee_word_t      ee_word;
  logic [SPM_DW-1:0] reg_rdata;
  logic [SPM_DW-1:0] pci_capability_id_word_hi;
  logic              wake_event_output;
  logic              soft_reset_active;
  logic              irq;
  int                n_mismatch = 0;
  int                check_count = 0;
  int                cyc = 0;

  spm_top u_spm_top (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eeprom_enable_pin(eeprom_enable_pin), .ee_word(ee_word),
    .power_state(power_state), .wake_event_enable(wake_event_enable),
    .wake_request(wake_request), .wake_event_output(wake_event_output),
    .pci_capability_id_word_hi(pci_capability_id_word_hi),
    .soft_reset_active(soft_reset_active), .irq(irq)
  );

  spm_ee_model u_spm_ee_model (
    .clk(clk), .fit(fit), .eeprom_enable_pin(eeprom_enable_pin),
    .ee_word(ee_word)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Single-cycle strobes; read data stands only in the next cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Every power state with enable off and on
  task automatic sweep(input logic [15:0] c);
    logic e;
    for (int s = 0; s < 4; s++) begin
      for (int n = 0; n < 2; n++) begin
        @(posedge clk);
        power_state <= spm_pstate_t'(s);
        wake_event_enable <= n[0];
        wake_request <= 1'b1;
        @(posedge clk);
        #1;
        e = n[0] && (s == 3 || (s == 1 && c[12]) || (s == 2 && c[13]));
        chk({15'h0, wake_event_output}, {15'h0, e});
      end
    end
  endtask

  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(SPM_OFF_GLOBAL_SOFT_RESET, 16'h0000);
    rd(SPM_OFF_PM_CAPS, SPM_CAPS_RESET);
    rd(16'h0300, 16'h0000);
    // No load while the strap is low
    u_spm_ee_model.send(SPM_EE_CFG_ADDR, 16'hFFFF);
    rd(SPM_OFF_PM_CAPS, SPM_CAPS_RESET);
    @(posedge clk);
    fit <= 1'b1;
    wr(SPM_OFF_IRQ_MASK, 16'h0001);
    rd(SPM_OFF_IRQ_MASK, 16'h0001);
    u_spm_ee_model.send(8'h05, 16'hFFFF);
    wr(SPM_OFF_PM_CAPS, 16'hFFFF);
    rd(SPM_OFF_PM_CAPS, SPM_CAPS_RESET);
    u_spm_ee_model.send(SPM_EE_CFG_ADDR, 16'hFFFF);
    rd(SPM_OFF_PM_CAPS, 16'h762F);
    chk(pci_capability_id_word_hi, 16'h762F);
    chk({15'h0, irq}, 16'h0001);
    wr(SPM_OFF_IRQ_STATUS, 16'h0001);
    rd(SPM_OFF_IRQ_STATUS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    sweep(16'h762F);
    // Only the D1 flag loaded, so D2 must stay quiet
    u_spm_ee_model.send(SPM_EE_CFG_ADDR, 16'h1000);
    sweep(16'h5000);
    rd(SPM_OFF_IRQ_STATUS, 16'h0003);
    chk({15'h0, irq}, 16'h0001);
    // Soft reset with a live wake request
    wr(SPM_OFF_GLOBAL_SOFT_RESET, 16'hFFFF);
    rd(SPM_OFF_GLOBAL_SOFT_RESET, 16'h0001);
    chk({15'h0, soft_reset_active}, 16'h0001);
    // View: D3 hot, wake blanked, strap high, soft reset set
    rd(SPM_OFF_PM_VIEW, 16'h001B);
    chk({14'h0, wake_event_output, irq}, 16'h0000);
    wr(SPM_OFF_IRQ_MASK, 16'h0003);
    rd(SPM_OFF_IRQ_MASK, 16'h0000);
    rd(SPM_OFF_PM_CAPS, 16'h5000);
    wr(SPM_OFF_GLOBAL_SOFT_RESET, 16'h0000);
    rd(SPM_OFF_GLOBAL_SOFT_RESET, 16'h0000);
    chk({15'h0, wake_event_output}, 16'h0001);
    rd(SPM_OFF_IRQ_STATUS, 16'h0006);
    @(posedge clk);
    fit <= 1'b0;
    rd(SPM_OFF_PM_CAPS, SPM_CAPS_RESET);
    give_verdict();
  end
endmodule // tb_spm_top

`default_nettype wire
